// ==== src/serial_command_line_frontend.sv ====
// line editing, echo, prompt and flow control for the serial command port
`timescale 1ns/100ps
module serial_command_line_frontend
    import cli_pkg::*;
#(
    parameter int LOOP_TIMEOUT = LOOP_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic line_valid,
    output logic [CNT_W-1:0] line_len,
    input wire logic [BUF_AW-1:0] line_rd_addr,
    output logic [7:0] line_rd_data,
    input wire logic line_done,
    output logic [1:0] baud_sel,
    output logic [15:0] baud_div
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PARSE = 3'b010,
        ST_LOOP = 3'b100
    } state_e;

    state_e state_ff;
    state_e nxt_state;
    logic waitreq_ff;
    logic [31:0] readdata_ff;
    logic echo_ff;
    logic xon_ff;
    logic [1:0] baud_ff;
    logic [15:0] div_ff;
    logic loop_req_ff;
    logic pass_ff;
    logic fail_ff;
    logic [19:0] loop_tmr_ff;
    logic pend_valid_ff;
    logic [7:0] pend_data_ff;
    logic pend_dup_ff;
    logic [7:0] prev_term_ff;
    logic line_valid_ff;
    logic done_seen_ff;

    logic seq_busy;
    logic seq_load;
    logic [2:0] seq_n;
    logic [7:0] seq_b0;
    logic [7:0] seq_b1;
    logic [7:0] seq_b2;
    logic [7:0] seq_b3;
    logic [CNT_W-1:0] buf_cnt;
    logic buf_full;
    logic buf_push;
    logic buf_pop;
    logic buf_clear;
    logic take;
    logic is_term;
    logic is_bs;
    logic is_ctrl;
    logic rx_is_term;
    logic loop_start;
    logic reply_go;
    logic wr_ack;
    logic [1:0] wr_baud;

    assign avs_waitrequest = waitreq_ff;
    assign avs_readdata = readdata_ff;
    assign line_valid = line_valid_ff;
    assign baud_sel = baud_ff;
    assign baud_div = div_ff;
    assign tx_valid = seq_busy;

    assign is_term = (pend_data_ff == CH_CR) || (pend_data_ff == CH_LF);
    assign is_bs = (pend_data_ff == CH_BS);
    assign is_ctrl = (pend_data_ff <= CH_CTRL_MAX);
    assign rx_is_term = (rx_data == CH_CR) || (rx_data == CH_LF);
    assign take = pend_valid_ff && state_ff == ST_IDLE && !seq_busy;
    assign loop_start = loop_req_ff && !pend_valid_ff && state_ff == ST_IDLE && !seq_busy;
    assign reply_go = state_ff == ST_PARSE && (done_seen_ff || line_done) && !seq_busy;
    assign wr_ack = avs_write && !waitreq_ff;
    assign wr_baud = avs_writedata[CTRL_BAUD_LO +: 2];

    line_store u_store (
        .clk(clk),
        .sys_rst(sys_rst),
        .push(buf_push),
        .push_data(pend_data_ff),
        .pop(buf_pop),
        .clear(buf_clear),
        .rd_addr(line_rd_addr),
        .rd_data(line_rd_data),
        .count(buf_cnt),
        .full(buf_full)
    );
    assign line_len = buf_cnt;

    reply_sequencer u_seq (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(seq_load),
        .n(seq_n),
        .b0(seq_b0),
        .b1(seq_b1),
        .b2(seq_b2),
        .b3(seq_b3),
        .tx_ready(tx_ready),
        .tx_valid(seq_busy),
        .tx_data(tx_data)
    );

    // avalon slave: waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitreq_ff <= 1'b1;
            readdata_ff <= '0;
        end else if ((avs_read || avs_write) && waitreq_ff) begin
            waitreq_ff <= 1'b0;
            readdata_ff <= '0;
            if (avs_address == ADDR_CTRL) begin
                readdata_ff[CTRL_ECHO] <= echo_ff;
                readdata_ff[CTRL_XON] <= xon_ff;
                readdata_ff[CTRL_BAUD_LO +: 2] <= baud_ff;
                readdata_ff[CTRL_LOOP] <= loop_req_ff;
            end else if (avs_address == ADDR_STAT) begin
                readdata_ff[STAT_LINE] <= line_valid_ff;
                readdata_ff[STAT_LBUSY] <= loop_req_ff || state_ff == ST_LOOP;
                readdata_ff[STAT_PASS] <= pass_ff;
                readdata_ff[STAT_FAIL] <= fail_ff;
                readdata_ff[STAT_CNT_LO +: CNT_W] <= buf_cnt;
            end
        end else begin
            waitreq_ff <= 1'b1;
        end
    end

    // mode and baud: reset gives echo on, flow control off, 9600
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            echo_ff <= ECHO_RST;
            xon_ff <= XON_RST;
            baud_ff <= BAUD_RST;
            div_ff <= DIV_1;
        end else if (wr_ack && avs_address == ADDR_CTRL) begin
            echo_ff <= avs_writedata[CTRL_ECHO];
            xon_ff <= avs_writedata[CTRL_XON];
            baud_ff <= wr_baud;
            // divisor follows the very next cycle, no frame boundary wait
            case (wr_baud)
                2'h0: div_ff <= DIV_0;
                2'h1: div_ff <= DIV_1;
                2'h2: div_ff <= DIV_2;
                default: div_ff <= DIV_3;
            endcase
        end
    end

    // loop-back request and result; a new request wins over the start clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_req_ff <= 1'b0;
            pass_ff <= 1'b0;
            fail_ff <= 1'b0;
            loop_tmr_ff <= '0;
        end else begin
            if (loop_start) begin
                loop_req_ff <= 1'b0;
                pass_ff <= 1'b0;
                fail_ff <= 1'b0;
                loop_tmr_ff <= '0;
            end else if (state_ff == ST_LOOP) begin
                loop_tmr_ff <= loop_tmr_ff + 20'h0_0001;
                if (rx_valid) begin
                    pass_ff <= (rx_data == LOOP_BYTE);
                    fail_ff <= (rx_data != LOOP_BYTE);
                end else if (loop_tmr_ff >= 20'(LOOP_TIMEOUT - 1)) begin
                    fail_ff <= 1'b1;
                end
            end
            if (wr_ack && avs_address == ADDR_CTRL && avs_writedata[CTRL_LOOP]) begin
                loop_req_ff <= 1'b1;
            end
        end
    end

    // one-deep holding slot; bytes arriving while it is full are dropped
    // unechoed, which the echo-checking host resends
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_valid_ff <= 1'b0;
            pend_data_ff <= '0;
            pend_dup_ff <= 1'b0;
            prev_term_ff <= '0;
        end else begin
            if (take) begin
                pend_valid_ff <= 1'b0;
            end
            if (rx_valid && state_ff != ST_LOOP) begin
                prev_term_ff <= rx_is_term ? rx_data : 8'h00;
                if (!pend_valid_ff || take) begin
                    pend_valid_ff <= 1'b1;
                    pend_data_ff <= rx_data;
                    // second of a CR LF or LF CR pair
                    pend_dup_ff <= rx_is_term && prev_term_ff != 8'h00
                        && prev_term_ff != rx_data;
                end
            end
        end
    end

    // line hand-off to the parser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_valid_ff <= 1'b0;
            done_seen_ff <= 1'b0;
        end else if (take && is_term && !pend_dup_ff) begin
            line_valid_ff <= 1'b1;
            done_seen_ff <= 1'b0;
        end else if (reply_go) begin
            line_valid_ff <= 1'b0;
            done_seen_ff <= 1'b0;
        end else if (state_ff == ST_PARSE && line_done) begin
            done_seen_ff <= 1'b1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take && is_term && !pend_dup_ff) begin
                    nxt_state = ST_PARSE;
                end else if (loop_start) begin
                    nxt_state = ST_LOOP;
                end
            end
            ST_PARSE: begin
                if (reply_go) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_LOOP: begin
                if (rx_valid || loop_tmr_ff >= 20'(LOOP_TIMEOUT - 1)) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // character actions and reply selection; prompt use skips echo and, with flow control on, the CR LF of the reply
    always_comb begin
        buf_push = 1'b0;
        buf_pop = 1'b0;
        buf_clear = reply_go;
        seq_load = 1'b0;
        seq_n = 3'h0;
        seq_b0 = CH_CR;
        seq_b1 = CH_LF;
        seq_b2 = CH_PROMPT;
        seq_b3 = CH_XON;
        if (reply_go) begin
            seq_load = 1'b1;
            if (echo_ff || !xon_ff) begin
                seq_n = xon_ff ? 3'h4 : 3'h3;
            end else begin
                seq_n = 3'h2;
                seq_b0 = CH_PROMPT;
                seq_b1 = CH_XON;
            end
        end else if (loop_start) begin
            seq_load = 1'b1;
            seq_n = 3'h1;
            seq_b0 = LOOP_BYTE;
        end else if (take) begin
            seq_load = 1'b1;
            if (is_term) begin
                if (pend_dup_ff) begin
                    seq_n = 3'h0;
                end else if (xon_ff) begin
                    seq_b0 = CH_XOFF;
                    seq_b1 = CH_CR;
                    seq_n = echo_ff ? 3'h2 : 3'h1;
                end else begin
                    seq_b0 = pend_data_ff;
                    seq_n = echo_ff ? 3'h1 : 3'h0;
                end
            end else if (is_bs) begin
                buf_pop = 1'b1;
                seq_b0 = CH_BS;
                seq_b1 = CH_SP;
                seq_b2 = CH_BS;
                seq_n = echo_ff ? 3'h3 : 3'h0;
            end else if (!is_ctrl) begin
                buf_push = !buf_full;
                seq_b0 = pend_data_ff;
                seq_n = (echo_ff && !buf_full) ? 3'h1 : 3'h0;
            end else begin
                seq_n = 3'h0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_term_parse;
        take && is_term && !pend_dup_ff |=> line_valid_ff && state_ff == ST_PARSE;
    endproperty
    a_term_parse: assert property (p_term_parse) else $error("terminator did not start parse");

    property p_bs_pop;
        take && is_bs && buf_cnt != '0 |=> buf_cnt == $past(buf_cnt) - 1'b1;
    endproperty
    a_bs_pop: assert property (p_bs_pop) else $error("backspace did not drop one char");

    property p_ctrl_ignored;
        take && is_ctrl && !is_term && !is_bs |=> buf_cnt == $past(buf_cnt) && !seq_busy;
    endproperty
    a_ctrl_ignored: assert property (p_ctrl_ignored) else $error("stray control acted on");

    property p_echo_char;
        take && !is_ctrl && echo_ff && !buf_full |=> seq_busy && tx_data == $past(pend_data_ff);
    endproperty
    a_echo_char: assert property (p_echo_char) else $error("character not echoed");

    property p_bs_echo;
        take && is_bs && echo_ff |=> seq_busy && tx_data == CH_BS;
    endproperty
    a_bs_echo: assert property (p_bs_echo) else $error("backspace echo missing");

    property p_dup;
        take && is_term && pend_dup_ff |=> !seq_busy && state_ff == ST_IDLE;
    endproperty
    a_dup: assert property (p_dup) else $error("second terminator was answered");

    property p_reply;
        reply_go && (echo_ff || !xon_ff) |=> seq_busy && tx_data == CH_CR && !line_valid_ff;
    endproperty
    a_reply: assert property (p_reply) else $error("line end reply wrong");

    property p_xoff;
        take && is_term && !pend_dup_ff && xon_ff |=> tx_data == CH_XOFF && seq_busy;
    endproperty
    a_xoff: assert property (p_xoff) else $error("flow-off code not sent first");

    property p_baud;
        wr_ack && avs_address == ADDR_CTRL && wr_baud == 2'h1 |=> div_ff == DIV_1 && baud_ff == 2'h1;
    endproperty
    a_baud: assert property (p_baud) else $error("baud change not immediate");

    property p_loop_pass;
        $rose(pass_ff) |-> $past(rx_valid) && $past(rx_data) == LOOP_BYTE;
    endproperty
    a_loop_pass: assert property (p_loop_pass) else $error("loop pass without echo byte");

    c_line: cover property (take && is_term ##[1:1000] reply_go);
    c_bs: cover property (take && is_bs && buf_cnt != '0);
    c_loop: cover property ($rose(pass_ff));
    c_dup: cover property (take && pend_dup_ff);
endmodule : serial_command_line_frontend

// ==== src/cli_pkg.sv ====
// constants for the serial command line front end
// Function
// - a carriage return or line feed ends the line and hands it to the parser
// - backspace removes the newest buffered character, never a line terminator
// - among control codes only carriage return, line feed and backspace act
// - after a line is parsed, carriage return then line feed goes back
// - with echo on every received non-control character is sent back unchanged unless the line buffer is full; bytes hitting a full holding slot are dropped
// - with echo on a backspace is answered by backspace, space, backspace
// - of a back-to-back CR LF or LF CR pair only the first is returned
// - echo is the default handshake, with no parity checking
// - after a line the device sends carriage return, line feed, greater-than
// - prompt mode sends no echo and, with flow control on, no CR LF after a line
// - with flow control a terminator returns off-code then CR, or off-code alone
// - after pausing the host, normal CR LF follows when echo is on
// - a loop-back self test passes only with transmit wired back to receive
// - reset gives 9600 baud, 8N1, echo on, flow control off
// - baud is 19200, 9600, 4800 or 2400 and changes take effect at once
package cli_pkg;
    localparam int CLK_HZ = 50_000_000;
    // characters
    localparam logic [7:0] CH_BS = 8'h08;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_PROMPT = 8'h3E;
    localparam logic [7:0] CH_XON = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam logic [7:0] CH_CTRL_MAX = 8'h1F;
    localparam logic [7:0] LOOP_BYTE = 8'h55;
    // line buffer
    localparam int BUF_DEPTH = 64;
    localparam int BUF_AW = 6;
    localparam int CNT_W = 7;
    // register byte offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    // control fields
    localparam int CTRL_ECHO = 0;
    localparam int CTRL_XON = 1;
    localparam int CTRL_BAUD_LO = 2;
    localparam int CTRL_LOOP = 4;
    // status fields
    localparam int STAT_LINE = 0;
    localparam int STAT_LBUSY = 1;
    localparam int STAT_PASS = 2;
    localparam int STAT_FAIL = 3;
    localparam int STAT_CNT_LO = 8;
    // reset values
    localparam logic ECHO_RST = 1'b1;
    localparam logic XON_RST = 1'b0;
    localparam logic [1:0] BAUD_RST = 2'h1;
    // baud codes 0..3 and clocks per bit, rounded to nearest
    localparam int BAUD_0 = 19200;
    localparam int BAUD_1 = 9600;
    localparam int BAUD_2 = 4800;
    localparam int BAUD_3 = 2400;
    localparam logic [15:0] DIV_0 = 16'((CLK_HZ + BAUD_0 / 2) / BAUD_0);
    localparam logic [15:0] DIV_1 = 16'((CLK_HZ + BAUD_1 / 2) / BAUD_1);
    localparam logic [15:0] DIV_2 = 16'((CLK_HZ + BAUD_2 / 2) / BAUD_2);
    localparam logic [15:0] DIV_3 = 16'((CLK_HZ + BAUD_3 / 2) / BAUD_3);
    // loop-back wait, longest time so rounds down
    localparam int LOOP_TIMEOUT_US = 10_000;
    localparam int LOOP_TIMEOUT_CYC = LOOP_TIMEOUT_US * (CLK_HZ / 1_000_000);
endpackage : cli_pkg

// ==== src/line_store.sv ====
// line buffer holding the characters of the command being typed
`timescale 1ns/100ps
module line_store
    import cli_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic pop,
    input wire logic clear,
    input wire logic [BUF_AW-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [CNT_W-1:0] count,
    output logic full
);
    logic [7:0] mem [BUF_DEPTH];
    logic [CNT_W-1:0] count_ff;
    logic [7:0] rd_data_ff;

    assign count = count_ff;
    assign rd_data = rd_data_ff;
    assign full = (count_ff == CNT_W'(BUF_DEPTH));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= '0;
        end else if (clear) begin
            count_ff <= '0;
        end else if (push && !full) begin
            count_ff <= count_ff + 1'b1;
        end else if (pop && count_ff != '0) begin
            // empty buffer stays empty
            count_ff <= count_ff - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push && !full && !clear) begin
            mem[count_ff[BUF_AW-1:0]] <= push_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule : line_store

// ==== src/reply_sequencer.sv ====
// holds up to four reply characters and hands them out one by one
`timescale 1ns/100ps
module reply_sequencer
    import cli_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [2:0] n,
    input wire logic [7:0] b0,
    input wire logic [7:0] b1,
    input wire logic [7:0] b2,
    input wire logic [7:0] b3,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data
);
    logic tx_valid_ff;
    logic [7:0] tx_data_ff;
    logic [7:0] q1_ff;
    logic [7:0] q2_ff;
    logic [7:0] q3_ff;
    logic [2:0] left_ff;

    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;

    // load is only issued while idle, so a load never overlaps a drain
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff <= '0;
            q1_ff <= '0;
            q2_ff <= '0;
            q3_ff <= '0;
            left_ff <= '0;
        end else if (load && !tx_valid_ff && n != 3'h0) begin
            tx_valid_ff <= 1'b1;
            tx_data_ff <= b0;
            q1_ff <= b1;
            q2_ff <= b2;
            q3_ff <= b3;
            left_ff <= n - 3'h1;
        end else if (tx_valid_ff && tx_ready) begin
            tx_valid_ff <= (left_ff != 3'h0);
            tx_data_ff <= q1_ff;
            q1_ff <= q2_ff;
            q2_ff <= q3_ff;
            left_ff <= (left_ff != 3'h0) ? left_ff - 3'h1 : 3'h0;
        end
    end
endmodule : reply_sequencer

// ==== verif/host_term.sv ====
// host terminal model: sends bytes, takes replies with random stalls
`timescale 1ns/100ps
module host_term (
    input wire logic clk,
    input wire logic loop_en,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    logic [7:0] got_q[$];
    logic hv = 1'b0, lv = 1'b0;
    logic [7:0] hd = 8'h00, ld = 8'h00;
    // a plug wired tx to rx replaces the host while looped
    assign rx_valid = loop_en ? lv : hv;
    assign rx_data = loop_en ? ld : hd;
    // every reply byte is kept for the bench to compare
    always @(posedge clk) begin
        tx_ready <= 1'($urandom_range(0, 1));
        lv <= loop_en && tx_valid && tx_ready;
        ld <= (tx_valid && tx_ready) ? tx_data : ~ld;
        if (tx_valid && tx_ready) got_q.push_back(tx_data);
    end
    // bench sends one byte, held valid for a single cycle
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        hv <= 1'b1;
        hd <= b;
        @(posedge clk);
        hv <= 1'b0;
        hd <= ~b;
    endtask : send
endmodule : host_term

// ==== verif/tb.sv ====
// testbench: front end against a queue-based reference model
`timescale 1ns/100ps
module tb;
    import cli_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, line_done = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
    logic avs_waitrequest, rx_valid, tx_valid, tx_ready, line_valid, loop_en = 1'b0;
    logic [7:0] rx_data, tx_data, line_rd_data, last = 8'h00;
    logic [CNT_W-1:0] line_len;
    logic [BUF_AW-1:0] line_rd_addr = '0;
    logic [1:0] baud_sel;
    logic [15:0] baud_div;
    logic [7:0] exp_q[$], lb[$];
    logic echo = 1'b1, flow = 1'b0, pend = 1'b0;
    int fails = 0, tests_run = 0, cyc = 0;
    always #10 clk = ~clk;
    serial_command_line_frontend #(.LOOP_TIMEOUT(200)) dut (.clk, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_valid,
        .rx_data, .tx_valid, .tx_data, .tx_ready, .line_valid, .line_len, .line_rd_addr,
        .line_rd_data, .line_done, .baud_sel, .baud_div);
    host_term host (.clk, .loop_en, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data);
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic cfg(input logic [31:0] d);
        bus(1'b1, ADDR_CTRL, d);
        echo = d[CTRL_ECHO];
        flow = d[CTRL_XON];
    endtask : cfg
    task automatic drain();
        for (int i = 0; i < 300 && host.got_q.size() < exp_q.size(); i++) @(posedge clk);
        repeat (12) @(posedge clk);
        chk("reply count", exp_q.size(), host.got_q.size());
        while (exp_q.size() > 0 && host.got_q.size() > 0)
            chk("reply byte", exp_q.pop_front(), host.got_q.pop_front());
        exp_q.delete();
        host.got_q.delete();
        chk("line length", lb.size(), line_len);
        chk("line valid", pend, line_valid);
    endtask : drain
    task automatic put(input logic [7:0] b);
        host.send(b);
        if (b > CH_CTRL_MAX) begin
            lb.push_back(b);
            if (echo) exp_q.push_back(b);
        end else if (b == CH_BS) begin
            if (lb.size() > 0) void'(lb.pop_back());
            if (echo) exp_q = {exp_q, CH_BS, CH_SP, CH_BS};
        end else if ((b == CH_CR || b == CH_LF) && !((last == CH_CR || last == CH_LF) && last != b)) begin
            pend = 1'b1;
            // with flow control on, the echoed terminator is always a carriage return
            if (flow) exp_q.push_back(CH_XOFF);
            if (echo) exp_q.push_back(flow ? CH_CR : b);
        end
        last = b;
        drain();
    endtask : put
    task automatic parse();
        foreach (lb[i]) begin
            line_rd_addr <= BUF_AW'(i);
            repeat (2) @(posedge clk);
            chk("line byte", lb[i], line_rd_data);
        end
        line_done <= 1'b1;
        @(posedge clk);
        line_done <= 1'b0;
        if (echo || !flow) exp_q = {exp_q, CH_CR, CH_LF, CH_PROMPT};
        else exp_q.push_back(CH_PROMPT);
        if (flow) exp_q.push_back(CH_XON);
        lb.delete();
        pend = 1'b0;
        drain();
    endtask : parse
    initial begin
        int bd[4] = '{19200, 9600, 4800, 2400};
        logic [31:0] mode[4] = '{32'h0000_0005, 32'h0000_0007, 32'h0000_0006, 32'h0000_0004};
        logic [7:0] ctl[4] = '{8'h00, 8'h1b, 8'h1f, 8'h07};
        void'($urandom(32'h0000_db04));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0005, rd);
        chk("divider reset", (CLK_HZ + 4800) / 9600, baud_div);
        bus(1'b1, 4'h8, 32'hffff_ffff);
        bus(1'b0, 4'h8, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, rd);
        for (int i = 0; i < 4; i++) begin
            cfg(32'h0000_0001 | (i << CTRL_BAUD_LO));
            // the write lands on the acknowledge edge; look one edge later
            @(posedge clk);
            chk("baud select", i, baud_sel);
            chk("baud divider", (CLK_HZ + bd[i] / 2) / bd[i], baud_div);
        end
        foreach (mode[m]) begin
            cfg(mode[m]);
            put(CH_BS);
            repeat (3) put(8'($urandom_range(8'h21, 8'h7e)));
            put(ctl[m]);
            put(CH_BS);
            put(m[0] ? CH_LF : CH_CR);
            put(m[0] ? CH_CR : CH_LF);
            parse();
        end
        loop_en <= 1'b1;
        cfg(32'h0000_0015);
        exp_q.push_back(LOOP_BYTE);
        repeat (300) @(posedge clk);
        bus(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("loop pass", 32'h0000_0004, rd & 32'h0000_000c);
        loop_en <= 1'b0;
        cfg(32'h0000_0015);
        exp_q.push_back(LOOP_BYTE);
        repeat (300) @(posedge clk);
        bus(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("loop fail", 32'h0000_0008, rd & 32'h0000_000c);
        drain();
        report_and_stop();
    end
endmodule : tb
